/* File: verilog/uart_fifo_ctrl.sv */
// UART FIFO control, DMA ready pins and AXI4-Lite register slave
// Function
// - Receive interrupt while occupancy at or above trigger
// - Keep filling receive FIFO until full
// - Control bits five and four read zero
// - DMA mode bit selects mode when FIFOs enabled, default 0
// - Mode 0 tx ready low while empty
// - Mode 0 rx ready low while data held
// - Mode 1 tx ready high only when full
// - Mode 1 rx ready low at trigger/time-out
// - Mode 1 rx ready back high only once empty
// - Tx flush empties FIFO, shifter untouched
// - Rx flush empties FIFO, shifter untouched
// - Flush bits self-clear, writing zero ignored
// - Trigger field picks 1, 4, 8, 14
// - Bit zero enables FIFOs, else single holding
// - Receive interrupt drops below trigger level
// - Status upper bits show FIFO enable
`timescale 1ns/1ps
module uart_fifo_ctrl
(
  // Clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  // AXI4-Lite write address and data
  input wire logic i_awvalid,
  input wire logic [7:0] i_awaddr,
  output logic o_awready,
  input wire logic i_wvalid,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_wready,
  // AXI4-Lite write response
  output logic o_bvalid,
  output logic [1:0] o_bresp,
  input wire logic i_bready,
  // AXI4-Lite read
  input wire logic i_arvalid,
  input wire logic [7:0] i_araddr,
  output logic o_arready,
  output logic o_rvalid,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic i_rready,
  // Receive shift engine side
  input uart_fifo_pkg::char_t i_rx_char,
  input wire logic i_rx_timeout,
  // Transmit shift engine side
  input wire logic i_tx_pop,
  output uart_fifo_pkg::char_t o_tx_char,
  // Pins and interrupts
  output logic o_tx_dma_ready_n,
  output logic o_rx_dma_ready_n,
  output logic o_rx_data_int,
  output logic o_irq
);
  import uart_fifo_pkg::*;
  // ==========================================================
  // Declarations
  fifo_ctrl_t fifo_control_reg_q;
  logic [DATA_W-1:0] tx_mem [FIFO_DEPTH];
  logic [DATA_W-1:0] rx_mem [FIFO_DEPTH];
  logic [PTR_W-1:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
  logic [CNT_W-1:0] tx_cnt_q, rx_cnt_q, cap, trig_lvl;
  logic [2:0] irq_sts_q, irq_mask_q, irq_evt;
  logic [7:0] aw_addr_q, ar_addr;
  logic [31:0] w_data_q, rd_word;
  logic [3:0] w_strb_q;
  logic aw_hs, w_hs, b_hs, ar_hs, r_hs, wr_go, tx_push, tx_pop, rx_push, rx_pop;
  logic rx_at_trig_q, rx_hold_q, rx_trig_now, wr_ctrl, rd_rx, rd_irq, addr_ok;
  // Map a trigger code onto its level
  function automatic logic [CNT_W-1:0] trig_of(input rx_trig_t sel);
    case (sel)
      TRIG_1: trig_of = TRIG_LVL_0;
      TRIG_4: trig_of = TRIG_LVL_1;
      TRIG_8: trig_of = TRIG_LVL_2;
      default: trig_of = TRIG_LVL_3;
    endcase
  endfunction
  // Address decoding shared by reads and writes
  function automatic logic is_mapped(input logic [7:0] a);
    if (a == OFS_FIFO_CTRL) is_mapped = 1'b1;
    else if (a == OFS_TX_DATA) is_mapped = 1'b1;
    else if (a == OFS_RX_DATA) is_mapped = 1'b1;
    else if (a == OFS_INT_STATUS) is_mapped = 1'b1;
    else if (a == OFS_IRQ_STATUS) is_mapped = 1'b1;
    else if (a == OFS_IRQ_MASK) is_mapped = 1'b1;
    else is_mapped = 1'b0;
  endfunction
  // ==========================================================
  // Bus handshakes
  assign aw_hs = i_awvalid & o_awready;
  assign w_hs = i_wvalid & o_wready;
  assign b_hs = o_bvalid & i_bready;
  assign ar_hs = i_arvalid & o_arready;
  assign r_hs = o_rvalid & i_rready;
  assign ar_addr = i_araddr;
  // Write fires once both halves are held and no response is pending
  assign wr_go = !o_awready & !o_wready & !o_bvalid;
  assign wr_ctrl = wr_go & (aw_addr_q == OFS_FIFO_CTRL) & w_strb_q[0];
  assign rd_rx = ar_hs & (ar_addr == OFS_RX_DATA);
  assign rd_irq = ar_hs & (ar_addr == OFS_IRQ_STATUS);
  assign addr_ok = is_mapped(ar_addr);
  // Write address and data channels, taken in either order
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end
    else if (i_ce)
    begin
      if (aw_hs)
      begin
        o_awready <= 1'b0;
        aw_addr_q <= i_awaddr;
      end
      else if (b_hs)
        o_awready <= 1'b1;
      if (w_hs)
      begin
        o_wready <= 1'b0;
        w_data_q <= i_wdata;
        w_strb_q <= i_wstrb;
      end
      else if (b_hs)
        o_wready <= 1'b1;
    end
  end
  // Write response
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
    end
    else if (i_ce)
    begin
      if (wr_go)
      begin
        o_bvalid <= 1'b1;
        o_bresp <= is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (b_hs)
        o_bvalid <= 1'b0;
    end
  end
  // ==========================================================
  // Read channel
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (ar_addr == OFS_FIFO_CTRL)
      rd_word[7:0] = {fifo_control_reg_q.rx_trigger_sel, 2'h0,
        fifo_control_reg_q[3:0]};
    else if (ar_addr == OFS_RX_DATA)
      rd_word[7:0] = rx_mem[rx_rp_q];
    else if (ar_addr == OFS_INT_STATUS)
    begin
      rd_word[7:6] = {2{fifo_control_reg_q.fifo_en}};
      rd_word[0] = !o_rx_data_int; // Low means pending
      rd_word[12:8] = rx_cnt_q;
      rd_word[20:16] = tx_cnt_q;
    end
    else if (ar_addr == OFS_IRQ_STATUS)
      rd_word[2:0] = irq_sts_q;
    else if (ar_addr == OFS_IRQ_MASK)
      rd_word[2:0] = irq_mask_q;
  end
  // One read outstanding; data captured with the address
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= RESP_OKAY;
    end
    else if (i_ce)
    begin
      if (ar_hs)
      begin
        o_arready <= 1'b0;
        o_rvalid <= 1'b1;
        o_rdata <= rd_word;
        o_rresp <= addr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (r_hs)
      begin
        o_arready <= 1'b1;
        o_rvalid <= 1'b0;
      end
    end
  end
  // ==========================================================
  // FIFO control register
  // Flush bits stand one cycle, long enough for the counters to clear
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      fifo_control_reg_q <= fifo_ctrl_t'({FCR_RESET[7:6], FCR_RESET[3:0]});
    else if (i_ce)
    begin
      fifo_control_reg_q.tx_fifo_flush <= 1'b0;
      fifo_control_reg_q.rx_fifo_flush <= 1'b0;
      if (wr_ctrl)
      begin
        fifo_control_reg_q.fifo_en <= w_data_q[FCR_EN_BIT];
        fifo_control_reg_q.dma_mode <= w_data_q[FCR_DMA_BIT];
        fifo_control_reg_q.rx_trigger_sel <=
          rx_trig_t'(w_data_q[FCR_TRIG_LSB +: 2]);
        fifo_control_reg_q.tx_fifo_flush <= w_data_q[FCR_TXFL_BIT];
        fifo_control_reg_q.rx_fifo_flush <= w_data_q[FCR_RXFL_BIT];
      end
    end
  end
  // ==========================================================
  // Occupancy limits
  // With FIFOs off only one character is held, as a holding register
  assign cap = fifo_control_reg_q.fifo_en ? CNT_FULL : CNT_ONE;
  assign trig_lvl = fifo_control_reg_q.fifo_en ?
    trig_of(fifo_control_reg_q.rx_trigger_sel) : CNT_ONE;
  assign tx_push = wr_go & (aw_addr_q == OFS_TX_DATA) & w_strb_q[0] &
    (tx_cnt_q < cap);
  assign tx_pop = i_tx_pop & (tx_cnt_q != 5'h00);
  // Keeps loading past the trigger until the FIFO is full
  assign rx_push = i_rx_char.valid & (rx_cnt_q < cap);
  assign rx_pop = rd_rx & (rx_cnt_q != 5'h00);
  // Storage arrays, written only; flushing moves pointers alone
  always_ff @(posedge i_core_clk)
  begin
    if (i_ce && tx_push)
      tx_mem[tx_wp_q] <= w_data_q[DATA_W-1:0];
    if (i_ce && rx_push)
      rx_mem[rx_wp_q] <= i_rx_char.data;
  end
  // Transmit pointers and count; shift engine never sees the flush
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      tx_wp_q <= 4'h0;
      tx_rp_q <= 4'h0;
      tx_cnt_q <= 5'h00;
    end
    else if (i_ce)
    begin
      if (fifo_control_reg_q.tx_fifo_flush)
      begin
        tx_wp_q <= 4'h0;
        tx_rp_q <= 4'h0;
        tx_cnt_q <= 5'h00;
      end
      else
      begin
        if (tx_push)
          tx_wp_q <= tx_wp_q + 4'h1;
        if (tx_pop)
          tx_rp_q <= tx_rp_q + 4'h1;
        tx_cnt_q <= tx_cnt_q + {4'h0, tx_push} - {4'h0, tx_pop};
      end
    end
  end
  // Receive pointers and count
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rx_wp_q <= 4'h0;
      rx_rp_q <= 4'h0;
      rx_cnt_q <= 5'h00;
    end
    else if (i_ce)
    begin
      if (fifo_control_reg_q.rx_fifo_flush)
      begin
        rx_wp_q <= 4'h0;
        rx_rp_q <= 4'h0;
        rx_cnt_q <= 5'h00;
      end
      else
      begin
        if (rx_push)
          rx_wp_q <= rx_wp_q + 4'h1;
        if (rx_pop)
          rx_rp_q <= rx_rp_q + 4'h1;
        rx_cnt_q <= rx_cnt_q + {4'h0, rx_push} - {4'h0, rx_pop};
      end
    end
  end
  // Head of the transmit FIFO offered to the shift engine
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_tx_char <= '0;
    else if (i_ce)
    begin
      o_tx_char.valid <= (tx_cnt_q != 5'h00);
      o_tx_char.data <= tx_mem[tx_rp_q];
    end
  end
  // ==========================================================
  // Receive data interrupt and DMA ready pins
  assign rx_trig_now = (rx_cnt_q >= trig_lvl);
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_rx_data_int <= 1'b0;
      rx_at_trig_q <= 1'b0;
      rx_hold_q <= 1'b0;
      o_rx_dma_ready_n <= 1'b1;
      o_tx_dma_ready_n <= 1'b0;
    end
    else if (i_ce)
    begin
      rx_at_trig_q <= rx_trig_now;
      // Set on reaching the trigger, dropped when below it
      o_rx_data_int <= rx_trig_now;
      // Block mode latch: armed at trigger or time-out, freed at empty
      if (rx_cnt_q == 5'h00)
        rx_hold_q <= 1'b0;
      else if (rx_trig_now || i_rx_timeout)
        rx_hold_q <= 1'b1;
      if (fifo_control_reg_q.fifo_en && fifo_control_reg_q.dma_mode)
      begin
        o_tx_dma_ready_n <= (tx_cnt_q == CNT_FULL);
        o_rx_dma_ready_n <= !(rx_hold_q && (rx_cnt_q != 5'h00));
      end
      else
      begin
        o_tx_dma_ready_n <= (tx_cnt_q != 5'h00);
        o_rx_dma_ready_n <= (rx_cnt_q == 5'h00);
      end
    end
  end
  // ==========================================================
  // Interrupt status, mask and line
  assign irq_evt[IRQ_RX_TRIG] = rx_trig_now & !rx_at_trig_q;
  assign irq_evt[IRQ_TX_EMPTY] = tx_pop & (tx_cnt_q == CNT_ONE) & !tx_push;
  assign irq_evt[IRQ_RX_OVERRUN] = i_rx_char.valid & !rx_push;
  // Read clears; an event in the same cycle survives the clear
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      irq_sts_q <= 3'h0;
      irq_mask_q <= IRQ_MASK_RESET;
      o_irq <= 1'b0;
    end
    else if (i_ce)
    begin
      irq_sts_q <= (rd_irq ? 3'h0 : irq_sts_q) | irq_evt;
      if (wr_go && (aw_addr_q == OFS_IRQ_MASK) && w_strb_q[0])
        irq_mask_q <= w_data_q[2:0];
      o_irq <= |(irq_sts_q & irq_mask_q);
    end
  end
endmodule

/* File: common/uart_fifo_pkg.sv */
// Constants and types for the UART FIFO control block
package uart_fifo_pkg;
  // ==========================================================
  // Sizes
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned PTR_W = 4;
  localparam int unsigned CNT_W = 5;
  localparam int unsigned DATA_W = 8;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_FIFO_CTRL = 8'h00;
  localparam logic [7:0] OFS_TX_DATA = 8'h04;
  localparam logic [7:0] OFS_RX_DATA = 8'h08;
  localparam logic [7:0] OFS_INT_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  // ==========================================================
  // Control register field positions
  localparam int unsigned FCR_EN_BIT = 0;
  localparam int unsigned FCR_RXFL_BIT = 1;
  localparam int unsigned FCR_TXFL_BIT = 2;
  localparam int unsigned FCR_DMA_BIT = 3;
  localparam int unsigned FCR_TRIG_LSB = 6;
  // ==========================================================
  // Reset values
  localparam logic [7:0] FCR_RESET = 8'h00;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
  // ==========================================================
  // Trigger levels
  localparam logic [CNT_W-1:0] TRIG_LVL_0 = 5'h01;
  localparam logic [CNT_W-1:0] TRIG_LVL_1 = 5'h04;
  localparam logic [CNT_W-1:0] TRIG_LVL_2 = 5'h08;
  localparam logic [CNT_W-1:0] TRIG_LVL_3 = 5'h0E;
  // ==========================================================
  // Interrupt event bits
  localparam int unsigned IRQ_RX_TRIG = 0;
  localparam int unsigned IRQ_TX_EMPTY = 1;
  localparam int unsigned IRQ_RX_OVERRUN = 2;
  // ==========================================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {TRIG_1, TRIG_4, TRIG_8, TRIG_14} rx_trig_t;
  typedef struct packed {
    rx_trig_t rx_trigger_sel;
    logic dma_mode;
    logic tx_fifo_flush;
    logic rx_fifo_flush;
    logic fifo_en;
  } fifo_ctrl_t;
  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
  } char_t;
endpackage

/* File: bench/uart_fifo_ctrl_asserts.sv */
// Port checker for the UART FIFO control block
`timescale 1ns/1ps
module uart_fifo_ctrl_asserts
  import uart_fifo_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Bus and engine inputs
  input wire logic i_arvalid,
  input wire logic i_bready,
  input wire logic i_rready,
  input wire logic i_rx_timeout,
  input uart_fifo_pkg::char_t i_rx_char,
  // Watched outputs
  input wire logic o_awready,
  input wire logic o_arready,
  input wire logic o_bvalid,
  input wire logic o_rvalid,
  input wire logic [31:0] o_rdata,
  input uart_fifo_pkg::char_t o_tx_char,
  input wire logic o_tx_dma_ready_n,
  input wire logic o_rx_dma_ready_n,
  input wire logic o_rx_data_int
);
  logic [2:0] age_q;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  // ==========================================================
  // Cycles since a bus answer; pins may move after any register access
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      age_q <= 3'h7;
    else if (o_bvalid || o_rvalid)
      age_q <= 3'h0;
    else if (age_q != 3'h7)
      age_q <= age_q + 3'h1;
  end
  // ==========================================================
  // Ready pins and receive interrupt
  property p_tx_pin; o_tx_dma_ready_n |-> o_tx_char.valid; endproperty
  a_tx_pin: assert property (p_tx_pin)
    else $error("tx ready pin high with empty tx fifo");
  // Block mode arms a latch first, so a trigger char shows one edge later
  property p_rx_fall;
    $fell(o_rx_dma_ready_n) |-> $past(i_rx_char.valid, 2) || $past(i_rx_timeout, 2)
      || $past(i_rx_timeout, 3) || $past(i_rx_char.valid, 3) || age_q < 3'h5;
  endproperty
  a_rx_fall: assert property (p_rx_fall)
    else $error("rx ready pin fell without a cause");
  property p_rx_rise; $rose(o_rx_dma_ready_n) |-> age_q < 3'h5; endproperty
  a_rx_rise: assert property (p_rx_rise)
    else $error("rx ready pin rose without a read or flush");
  property p_int_rise;
    $rose(o_rx_data_int) |-> $past(i_rx_char.valid, 2) || age_q < 3'h5;
  endproperty
  a_int_rise: assert property (p_int_rise)
    else $error("rx interrupt rose without a new char");
  property p_int_fall; $fell(o_rx_data_int) |-> age_q < 3'h5; endproperty
  a_int_fall: assert property (p_int_fall)
    else $error("rx interrupt fell without a read or write");
  // ==========================================================
  // Register bus handshakes
  property p_b_hold; o_bvalid && !i_bready |=> o_bvalid; endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  property p_r_hold; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata); endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data not held");
  property p_ar_ans; i_arvalid && o_arready |=> o_rvalid; endproperty
  a_ar_ans: assert property (p_ar_ans)
    else $error("read answer late");
  property p_aw_block; o_bvalid |-> !o_awready; endproperty
  a_aw_block: assert property (p_aw_block)
    else $error("write address taken while response pending");
endmodule

bind uart_fifo_ctrl uart_fifo_ctrl_asserts uart_fifo_ctrl_asserts_inst (.*);

/* File: bench/uart_engine_model.sv */
// Behavioural shift engines that feed the rx FIFO and drain the tx FIFO
`timescale 1ns/1ps
module uart_engine_model
  import uart_fifo_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Requests from the bench
  input wire logic i_go,
  input wire logic [4:0] i_cnt,
  input wire logic i_slow,
  input wire logic i_pop_go,
  // Toward the block and the bench
  output uart_fifo_pkg::char_t o_char,
  output logic o_pop,
  output logic o_busy
);
  logic [4:0] left_q;
  logic gap_q;
  logic [7:0] seq_q;
  // One char a cycle, or every other cycle when slow
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      left_q <= 5'h00;
      gap_q <= 1'b0;
      seq_q <= 8'hA0;
      o_char <= '0;
    end
    else if (i_go)
    begin
      left_q <= i_cnt;
      o_char.valid <= 1'b0;
    end
    else if (left_q != 5'h00 && !gap_q)
    begin
      o_char <= '{valid: 1'b1, data: seq_q};
      seq_q <= seq_q + 8'h01;
      left_q <= left_q - 5'h01;
      gap_q <= i_slow;
    end
    else
    begin
      // Idle data inverts so a stale byte is never taken as new
      o_char <= '{valid: 1'b0, data: ~o_char.data};
      gap_q <= 1'b0;
    end
  end
  // One pop pulse per request
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_pop <= 1'b0;
    else
      o_pop <= i_pop_go;
  end
  assign o_busy = (left_q != 5'h00);
endmodule

/* File: bench/uart_fifo_control_dma_ready_test.sv */
// Self-checking bench for the UART FIFO control block
`timescale 1ns/1ps
module uart_fifo_control_dma_ready_test;
  import uart_fifo_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_ce = 1'b1;
  logic [3:0] i_wstrb = 4'hF;
  logic i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_rx_timeout, i_tx_pop;
  logic [7:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
  logic o_tx_dma_ready_n, o_rx_dma_ready_n, o_rx_data_int;
  logic [1:0] o_bresp, o_rresp;
  char_t i_rx_char, o_tx_char;
  logic go, slow, pop_go, busy;
  logic [4:0] cnt;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  // ==========================================================
  // Clock, design and engines
  always #10 i_core_clk = ~i_core_clk;
  uart_fifo_ctrl uart_fifo_ctrl_inst (.*);
  uart_engine_model uart_engine_model_inst (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .i_go(go), .i_cnt(cnt), .i_slow(slow), .i_pop_go(pop_go), .o_char(i_rx_char),
    .o_pop(i_tx_pop), .o_busy(busy));
  // ==========================================================
  // Shared tasks
  task automatic test_done;
    if (fail_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR %0t got %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge i_core_clk);
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_awaddr <= a;
    i_wdata <= d;
    i_bready <= 1'b1;
    // Each channel let go once taken; response closes the write
    do
    begin
      @(posedge i_core_clk);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
    end while (!o_bvalid);
    i_bready <= 1'b0;
    chk(o_bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge i_core_clk);
    i_arvalid <= 1'b1;
    i_araddr <= a;
    i_rready <= 1'b1;
    do
    begin
      @(posedge i_core_clk);
      if (o_arready) i_arvalid <= 1'b0;
    end while (!o_rvalid);
    d = o_rdata;
    rs = o_rresp;
    i_rready <= 1'b0;
  endtask
  // Pins settle a few edges after the engine finishes
  task automatic feed(input logic [4:0] n);
    @(posedge i_core_clk);
    go <= 1'b1;
    cnt <= n;
    @(posedge i_core_clk);
    go <= 1'b0;
    do @(posedge i_core_clk); while (busy);
    repeat (4) @(posedge i_core_clk);
  endtask
  task automatic pop;
    @(posedge i_core_clk);
    pop_go <= 1'b1;
    @(posedge i_core_clk);
    pop_go <= 1'b0;
    repeat (4) @(posedge i_core_clk);
  endtask
  // ==========================================================
  // Scenarios
  task automatic s_reset;
    logic [31:0] d;
    logic [1:0] rs;
    chk(o_tx_dma_ready_n, 1'b0);
    chk(o_rx_dma_ready_n, 1'b1);
    rd(OFS_FIFO_CTRL, d, rs);
    chk(d, 32'h0);
    rd(OFS_INT_STATUS, d, rs);
    chk(d[7:6], 2'h0);
    rd(8'h18, d, rs);
    chk(rs, RESP_SLVERR);
    chk(d, 32'h0);
    wr(8'h18, 32'hFF, RESP_SLVERR);
  endtask
  task automatic s_mode0;
    logic [31:0] d;
    logic [1:0] rs;
    wr(OFS_FIFO_CTRL, 32'h01, RESP_OKAY);
    wr(OFS_IRQ_MASK, 32'h01, RESP_OKAY);
    feed(5'h01);
    chk(o_rx_dma_ready_n, 1'b0);
    chk(o_rx_data_int, 1'b1);
    chk(o_irq, 1'b1);
    rd(OFS_IRQ_STATUS, d, rs);
    chk(d[0], 1'b1);
    repeat (3) @(posedge i_core_clk);
    chk(o_irq, 1'b0);
    wr(OFS_TX_DATA, 32'h5A, RESP_OKAY);
    repeat (3) @(posedge i_core_clk);
    chk(o_tx_dma_ready_n, 1'b1);
    chk(o_tx_char.data, 8'h5A);
    pop;
    chk(o_tx_dma_ready_n, 1'b0);
    rd(OFS_INT_STATUS, d, rs);
    chk(d[7:6], 2'h3);
    rd(OFS_RX_DATA, d, rs);
    chk(d[7:0], 8'hA0);
    repeat (3) @(posedge i_core_clk);
    chk(o_rx_dma_ready_n, 1'b1);
    chk(o_rx_data_int, 1'b0);
  endtask
  task automatic s_trig;
    logic [31:0] d;
    logic [1:0] rs;
    logic [4:0] lvl [4];
    lvl = '{5'h01, 5'h04, 5'h08, 5'h0E};
    // Every trigger code, mode 1, receive FIFO flushed first
    for (int k = 0; k < 4; k++)
    begin
      wr(OFS_FIFO_CTRL, {24'h0, 2'(k), 6'h0B}, RESP_OKAY);
      feed(lvl[k] - 5'h01);
      chk(o_rx_data_int, 1'b0);
      chk(o_rx_dma_ready_n, 1'b1);
      feed(5'h01);
      chk(o_rx_data_int, 1'b1);
      chk(o_rx_dma_ready_n, 1'b0);
      rd(OFS_RX_DATA, d, rs);
      repeat (3) @(posedge i_core_clk);
      chk(o_rx_data_int, 1'b0);
      chk(o_rx_dma_ready_n, k == 0);
      rd(OFS_FIFO_CTRL, d, rs);
      chk(d, {24'h0, 2'(k), 6'h09});
    end
  endtask
  task automatic s_full;
    logic [31:0] d;
    logic [1:0] rs;
    wr(OFS_FIFO_CTRL, 32'hCB, RESP_OKAY);
    wr(OFS_IRQ_MASK, 32'h00, RESP_OKAY);
    rd(OFS_IRQ_STATUS, d, rs);
    slow <= 1'b1;
    feed(5'h14);
    rd(OFS_INT_STATUS, d, rs);
    chk(d[12:8], 5'h10);
    chk(o_irq, 1'b0);
    wr(OFS_IRQ_MASK, 32'h04, RESP_OKAY);
    repeat (2) @(posedge i_core_clk);
    chk(o_irq, 1'b1);
    rd(OFS_IRQ_STATUS, d, rs);
    chk(d[2], 1'b1);
    repeat (3) @(posedge i_core_clk);
    chk(o_irq, 1'b0);
    for (int i = 0; i < 16; i++)
      wr(OFS_TX_DATA, 32'(i), RESP_OKAY);
    repeat (3) @(posedge i_core_clk);
    chk(o_tx_dma_ready_n, 1'b1);
    pop;
    chk(o_tx_dma_ready_n, 1'b0);
    wr(OFS_FIFO_CTRL, 32'hCD, RESP_OKAY);
    repeat (3) @(posedge i_core_clk);
    chk(o_tx_char.valid, 1'b0);
    rd(OFS_INT_STATUS, d, rs);
    chk(d[20:8], 13'h0010);
  endtask
  task automatic s_off;
    logic [31:0] d;
    logic [1:0] rs;
    wr(OFS_FIFO_CTRL, 32'h0B, RESP_OKAY);
    wr(OFS_FIFO_CTRL, 32'h08, RESP_OKAY);
    feed(5'h02);
    rd(OFS_INT_STATUS, d, rs);
    chk(d[12:8], 5'h01);
    chk(d[7:6], 2'h0);
    chk(o_rx_dma_ready_n, 1'b0);
    wr(OFS_TX_DATA, 32'h33, RESP_OKAY);
    repeat (3) @(posedge i_core_clk);
    chk(o_tx_dma_ready_n, 1'b1);
  endtask
  task automatic s_timeout;
    logic [31:0] d;
    logic [1:0] rs;
    wr(OFS_FIFO_CTRL, 32'hCB, RESP_OKAY);
    feed(5'h01);
    chk(o_rx_dma_ready_n, 1'b1);
    @(posedge i_core_clk);
    i_rx_timeout <= 1'b1;
    @(posedge i_core_clk);
    i_rx_timeout <= 1'b0;
    repeat (4) @(posedge i_core_clk);
    chk(o_rx_dma_ready_n, 1'b0);
    rd(OFS_RX_DATA, d, rs);
    repeat (3) @(posedge i_core_clk);
    chk(o_rx_dma_ready_n, 1'b1);
  endtask
  // ==========================================================
  // Watchdog against a hung handshake
  always @(posedge i_core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      $display("ERROR %0t run timed out", $time);
      test_done;
    end
  end
  // Main sequence
  initial
  begin
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_rx_timeout} = '0;
    {i_awaddr, i_araddr, i_wdata} = '0;
    {go, slow, pop_go, cnt} = '0;
    repeat (20) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    s_reset;
    s_mode0;
    s_trig;
    s_full;
    s_off;
    s_timeout;
    test_done;
  end
endmodule
